/* File: logic/pbc4_pkg.sv */
// constants and types shared by both ends of the presettable 4-bit counter link
package pbc4_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // count field
    localparam int COUNT_W = 4;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 4'hF;
    localparam logic [COUNT_W-1:0] COUNT_MIN = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
    localparam logic [COUNT_W-1:0] PRESET_RESET = 4'h0;
    localparam int COUNT_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////
    // control levels driven by the system end, and the flag state, after reset
    localparam logic CLEAR_N_RESET = 1'b0;
    localparam logic LOAD_N_RESET = 1'b1;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // operating modes, listed from lowest to highest precedence
    typedef enum logic [1:0] {
        PBC4_MODE_HOLD  = 2'b00,
        PBC4_MODE_COUNT = 2'b01,
        PBC4_MODE_LOAD  = 2'b10,
        PBC4_MODE_CLEAR = 2'b11
    } pbc4_mode_t;

    localparam pbc4_mode_t MODE_RESET = PBC4_MODE_CLEAR;

endpackage

/* File: logic/pbc4_if.sv */
// wires between the counter device and the system logic that drives it
`timescale 1ns/100ps
`default_nettype none

interface pbc4_if;
    import pbc4_pkg::*;

    // controls from the system end
    logic master_clear_n;
    logic load_enable_n;
    logic count_enable_parallel;
    logic count_enable_trickle;
    logic [COUNT_W-1:0] preset_value;

    // results from the device end
    logic [COUNT_W-1:0] count_value;
    logic terminal_count_flag;

    modport device (
        input master_clear_n,
        input load_enable_n,
        input count_enable_parallel,
        input count_enable_trickle,
        input preset_value,
        output count_value,
        output terminal_count_flag
    );

    modport system (
        output master_clear_n,
        output load_enable_n,
        output count_enable_parallel,
        output count_enable_trickle,
        output preset_value,
        input count_value,
        input terminal_count_flag
    );

endinterface

`default_nettype wire

/* File: logic/pbc4_device.sv */
// presettable modulo-16 up-counter with asynchronous clear and terminal count
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pbc4_device
    import pbc4_pkg::*;
(
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,

    // link to the system end
    pbc4_if.device link,

    // observation of the counter
    output logic [COUNT_W-1:0] count_o,
    output pbc4_mode_t mode_o,
    output logic wrap_o,
    output logic term_count_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        pbc4_mode_t mode;
        logic wrap;
    } pbc4_dev_state_t;

    localparam pbc4_dev_state_t STATE_RESET = '{
        count: COUNT_RESET,
        mode: MODE_RESET,
        wrap: FLAG_RESET
    };

    pbc4_dev_state_t state_reg;
    pbc4_dev_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode

    logic both_enables;
    logic count_up;
    pbc4_mode_t mode_sel;

    assign both_enables = link.count_enable_parallel & link.count_enable_trickle;

    always_comb begin
        // clear is handled by the flip-flops themselves, so here only load to hold
        if (!link.load_enable_n) begin
            mode_sel = PBC4_MODE_LOAD;
        end else if (both_enables) begin
            mode_sel = PBC4_MODE_COUNT;
        end else begin
            mode_sel = PBC4_MODE_HOLD;
        end
    end

    assign count_up = (mode_sel == PBC4_MODE_COUNT);

    ////////////////////////////////////////////////////////////////////////////
    // increment as a synchronous carry chain, bit zero lowest weight

    logic [COUNT_W:0] carry;
    logic [COUNT_W-1:0] count_inc;

    assign carry[COUNT_LSB] = 1'b1;

    generate
        for (genvar b = 0; b < COUNT_W; b++) begin : g_inc
            // carry out of the top bit is dropped, giving the wrap to zero
            assign count_inc[b] = state_reg.count[b] ^ carry[b];
            assign carry[b+1] = carry[b] & state_reg.count[b];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;
        state_next.mode = mode_sel;
        state_next.wrap = 1'b0;
        unique case (mode_sel)
            PBC4_MODE_LOAD: begin
                // enables are ignored while loading
                state_next.count = link.preset_value;
            end
            PBC4_MODE_COUNT: begin
                state_next.count = count_inc;
                state_next.wrap = (state_reg.count == COUNT_MAX);
            end
            PBC4_MODE_HOLD: begin
                state_next.count = state_reg.count;
            end
            PBC4_MODE_CLEAR: begin
                state_next.count = COUNT_RESET;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers: clear acts at once, everything else on the rising edge

    always_ff @(posedge clock_i or negedge link.master_clear_n) begin
        if (!link.master_clear_n) begin
            // the clear overrides reset, enable, load and count alike
            state_reg <= STATE_RESET;
        end else if (!rst_n_i) begin
            state_reg <= STATE_RESET;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    logic term_count;

    // live trickle input, so a trickle change reaches the flag without a clock
    assign term_count = link.count_enable_trickle & (state_reg.count == COUNT_MAX);

    assign link.count_value = state_reg.count;
    assign link.terminal_count_flag = term_count;

    assign count_o = state_reg.count;
    assign mode_o = state_reg.mode;
    assign wrap_o = state_reg.wrap;
    assign term_count_o = term_count;

endmodule

`default_nettype wire

/* File: logic/pbc4_system.sv */
// system-side controller that drives one counter stage over the link
`timescale 1ns/100ps
`default_nettype none

module pbc4_system
    import pbc4_pkg::*;
(
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,

    // link to the counter device
    pbc4_if.system link,

    // commands
    input wire logic clear_req_i,
    input wire logic load_req_i,
    input wire logic [COUNT_W-1:0] load_data_i,
    input wire logic count_run_i,

    // cascade
    input wire logic carry_in_i,
    output logic carry_out_o,

    // results
    output logic [COUNT_W-1:0] count_o,
    output logic term_seen_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic clear_n;
        logic load_n;
        logic run;
        logic [COUNT_W-1:0] preset;
        logic [COUNT_W-1:0] count;
        logic term_seen;
    } pbc4_sys_state_t;

    localparam pbc4_sys_state_t STATE_RESET = '{
        clear_n: CLEAR_N_RESET,
        load_n: LOAD_N_RESET,
        run: ENABLE_RESET,
        preset: PRESET_RESET,
        count: COUNT_RESET,
        term_seen: FLAG_RESET
    };

    pbc4_sys_state_t state_reg;
    pbc4_sys_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;
        // clear comes from a flop so it cannot glitch the device
        state_next.clear_n = ~clear_req_i;
        state_next.load_n = ~load_req_i;
        state_next.run = count_run_i;
        if (load_req_i) begin
            state_next.preset = load_data_i;
        end
        state_next.count = link.count_value;
        // flag is sampled here into term_seen_o, while carry_out_o takes the live flag; never used as a clock or reset
        state_next.term_seen = link.terminal_count_flag;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= STATE_RESET;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign link.master_clear_n = state_reg.clear_n;
    assign link.load_enable_n = state_reg.load_n;
    assign link.preset_value = state_reg.preset;
    // lookahead: a first stage's flag may drive count_run_i of later stages
    assign link.count_enable_parallel = state_reg.run;
    // ripple: the previous stage's flag passes straight to the trickle enable
    assign link.count_enable_trickle = carry_in_i;
    assign carry_out_o = link.terminal_count_flag;

    assign count_o = state_reg.count;
    assign term_seen_o = state_reg.term_seen;

endmodule

`default_nettype wire

/* File: dv/pbc4_assertions.sv */
// concurrent checks on the link between counter device and system logic
`timescale 1ns/100ps
`default_nettype none
module pbc4_assertions
    import pbc4_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // link signals
    input wire logic master_clear_n,
    input wire logic load_enable_n,
    input wire logic count_enable_parallel,
    input wire logic count_enable_trickle,
    input wire logic [COUNT_W-1:0] preset_value,
    input wire logic [COUNT_W-1:0] count_value,
    input wire logic terminal_count_flag
);
    wire logic run;
    wire logic idle;
    assign run = count_enable_parallel & count_enable_trickle;
    assign idle = master_clear_n & load_enable_n;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////
    property p_count;
        idle && run |=> !master_clear_n || count_value == $past(count_value) + 4'h1;
    endproperty
    a_count: assert property (p_count) else $error("count did not step");
    property p_load;
        master_clear_n && !load_enable_n |=> !master_clear_n || count_value == $past(preset_value);
    endproperty
    a_load: assert property (p_load) else $error("preset not loaded");
    property p_hold;
        idle && !run |=> !master_clear_n || $stable(count_value);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved on hold");
    property p_clear;
        !master_clear_n |-> count_value == COUNT_MIN;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero count");
    property p_flag;
        terminal_count_flag == (count_enable_trickle && count_value == COUNT_MAX);
    endproperty
    a_flag: assert property (p_flag) else $error("terminal flag wrong");
    property p_prec;
        master_clear_n && !load_enable_n && run ##1 master_clear_n |-> count_value == $past(preset_value);
    endproperty
    a_prec: assert property (p_prec) else $error("count beat load");
    property p_wrap;
        idle && run && count_value == COUNT_MAX |=> !master_clear_n || count_value == COUNT_MIN;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to zero");
    property p_change;
        $changed(count_value) && master_clear_n && $past(master_clear_n) |-> $past(run) || !$past(load_enable_n);
    endproperty
    a_change: assert property (p_change) else $error("count changed without cause");
endmodule
`default_nettype wire

/* File: dv/presettable_binary_counter4_tb.sv */
// self-checking bench joining counter device and system end over the link
`timescale 1ns/100ps
`default_nettype none
module presettable_binary_counter4_tb
    import pbc4_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clr = 1'b0, ld = 1'b0, run = 1'b0, cin = 1'b1;
    logic [3:0] data = 4'h0;
    logic [3:0] sys_cnt;
    logic [1:0] mode;
    logic cout;
    logic wrap;
    int bad_count = 0, checks_done = 0, cycles = 0;
    pbc4_if link_if();
    pbc4_device pbc4_device_inst (.clock_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .link(link_if),
        .count_o(), .mode_o(mode), .wrap_o(wrap), .term_count_o());
    pbc4_system pbc4_system_inst (.clock_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .link(link_if),
        .clear_req_i(clr), .load_req_i(ld), .load_data_i(data), .count_run_i(run),
        .carry_in_i(cin), .carry_out_o(cout), .count_o(sys_cnt), .term_seen_o());
    pbc4_assertions pbc4_assertions_inst (.clock_i(clk), .rst_n_i(rst_n),
        .master_clear_n(link_if.master_clear_n), .load_enable_n(link_if.load_enable_n),
        .count_enable_parallel(link_if.count_enable_parallel),
        .count_enable_trickle(link_if.count_enable_trickle),
        .preset_value(link_if.preset_value), .count_value(link_if.count_value),
        .terminal_count_flag(link_if.terminal_count_flag));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [3:0] got, logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic load(logic [3:0] v);
        ld = 1'b1;
        data = v;
        tick(1);
        ld = 1'b0;
        tick(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_load();
        load(4'hA);
        chk(link_if.count_value, 4'hA);
        chk({2'h0, mode}, {2'h0, PBC4_MODE_LOAD});
        tick(1);
        chk(sys_cnt, 4'hA);
        $display("load test done");
    endtask
    task automatic t_wrap();
        load(4'hE);
        run = 1'b1;
        tick(2);
        chk(link_if.count_value, 4'hF);
        chk({3'h0, cout}, 4'h1);
        tick(1);
        chk(link_if.count_value, 4'h0);
        chk({3'h0, wrap}, 4'h1);
        chk({3'h0, link_if.terminal_count_flag}, 4'h0);
        run = 1'b0;
        tick(1);
        $display("wrap test done");
    endtask
    task automatic t_hold();
        load(4'hF);
        cin = 1'b0;
        #1;
        chk({3'h0, link_if.terminal_count_flag}, 4'h0);
        run = 1'b1;
        tick(3);
        chk(link_if.count_value, 4'hF);
        run = 1'b0;
        tick(1);
        cin = 1'b1;
        tick(2);
        chk(link_if.count_value, 4'hF);
        chk({3'h0, link_if.terminal_count_flag}, 4'h1);
        $display("hold test done");
    endtask
    task automatic t_prec();
        run = 1'b1;
        load(4'h3);
        chk(link_if.count_value, 4'h3);
        tick(1);
        chk(link_if.count_value, 4'h4);
        clr = 1'b1;
        ld = 1'b1;
        tick(1);
        chk(link_if.count_value, 4'h0);
        tick(2);
        chk(link_if.count_value, 4'h0);
        clr = 1'b0;
        ld = 1'b0;
        run = 1'b0;
        tick(2);
        $display("precedence test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        tick(20);
        rst_n = 1'b1;
        tick(1);
        t_load();
        t_wrap();
        t_hold();
        t_prec();
        conclude();
    end
endmodule
`default_nettype wire
